// ---- prh_handshake.sv ----
/*
  controller register handshake engine with a wishbone register slave.
  assumes the controller side writes the request word over the bus and
  module data gathering finishes when gatherDone is seen high.
*/
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
module prh_handshake import prh_pkg::*; #(
  parameter int CHANNELS = 16,
  parameter int FLASH_CYC = PRH_FLASH_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic gatherDone,
  input wire logic backupFail,
  input wire logic stackFail,
  input wire logic netFail,
  input wire logic majorFail,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  output logic busy,
  output logic lampGreen,
  output logic lampRed
);
  typedef struct packed {
    prh_state_type state;
    logic [4:0] idx;
    logic [15:0] request;
    logic [15:0] commState;
    logic [15:0] sysState;
    logic [15:0] errWord;
    logic majorFault;
    logic [CHANNELS-1:0][15:0] ctrlSetpoint;
    logic [CHANNELS-1:0][15:0] unitSetpoint;
    logic [31:0] flashCnt;
    logic flashPhase;
    logic [31:0] datOut;
    logic ack;
    logic busy;
    logic green;
    logic red;
  } prh_regs_type;

  prh_regs_type cur_r, cur_nxt;

  // ==========================================================
  // helpers
  function automatic logic [15:0] mergeLanes(logic [15:0] old, logic [31:0] d, logic [3:0] s);
    mergeLanes = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic isSetpoint(logic [7:0] a);
    isSetpoint = (a >= PRH_OFF_SETPOINT) && (a < PRH_OFF_SETPOINT + 8'(4 * CHANNELS));
  endfunction

  logic [7:0] spIdx;
  assign spIdx = 8'((wbAdr - PRH_OFF_SETPOINT) >> 2);

  // ==========================================================
  // next state
  always_comb begin
    logic req;
    cur_nxt = cur_r;
    req = wbCyc && wbStb && !cur_r.ack;
    cur_nxt.ack = req;
    // ======================================================
    // bus reads
    if (req && !wbWe) begin
      unique case (wbAdr)
        PRH_OFF_CTRL: cur_nxt.datOut = {29'h0, cur_r.majorFault, cur_r.busy, cur_r.green};
        PRH_OFF_REQUEST: cur_nxt.datOut = {16'h0, cur_r.request};
        PRH_OFF_STATE: cur_nxt.datOut = {16'h0, cur_r.commState};
        PRH_OFF_SYSSTATE: cur_nxt.datOut = {16'h0, cur_r.sysState};
        PRH_OFF_ERROR: cur_nxt.datOut = {16'h0, cur_r.errWord};
        PRH_OFF_FAULT: cur_nxt.datOut = {31'h0, cur_r.majorFault};
        default: cur_nxt.datOut = isSetpoint(wbAdr) ?
          {16'h0, cur_r.ctrlSetpoint[spIdx[4:0]]} : 32'h0;
      endcase
    end
    // ======================================================
    // bus writes; controller owns request word and setpoint area
    if (req && wbWe) begin
      if (wbAdr == PRH_OFF_REQUEST) begin
        // hardware clear has its own path below; a write only adds bits
        cur_nxt.request = cur_r.request | mergeLanes(16'h0, wbDatIn, wbSel);
      end
      if (wbAdr == PRH_OFF_ERROR) begin
        cur_nxt.errWord = cur_r.errWord & ~mergeLanes(16'h0, wbDatIn, wbSel);
      end
      if (isSetpoint(wbAdr)) begin
        cur_nxt.ctrlSetpoint[spIdx[4:0]] = mergeLanes(cur_r.ctrlSetpoint[spIdx[4:0]],
          wbDatIn, wbSel);
      end
    end
    // ======================================================
    // transfer engine, one word per cycle
    unique case (cur_r.state)
      PRH_GATHER: begin
        if (gatherDone) begin
          cur_nxt.state = PRH_MONINIT;
          cur_nxt.sysState = PRH_SYS_READY;
          cur_nxt.idx = 5'h0;
        end
      end
      PRH_MONINIT, PRH_MONWRITE: begin
        cur_nxt.ctrlSetpoint[cur_r.idx] = cur_r.unitSetpoint[cur_r.idx];
        cur_nxt.idx = cur_r.idx + 5'h1;
        if (cur_r.idx == 5'(CHANNELS - 1)) begin
          cur_nxt.state = PRH_IDLE;
          if (cur_r.state == PRH_MONWRITE) begin
            cur_nxt.request[PRH_REQ_MON_BIT] = 1'b0;
            cur_nxt.commState[PRH_ST_MON_BIT] = 1'b1;
          end
        end
      end
      PRH_SETREAD: begin
        cur_nxt.unitSetpoint[cur_r.idx] = cur_r.ctrlSetpoint[cur_r.idx];
        cur_nxt.idx = cur_r.idx + 5'h1;
        if (cur_r.idx == 5'(CHANNELS - 1)) begin
          cur_nxt.state = PRH_IDLE;
          cur_nxt.request[PRH_REQ_SET_BIT] = 1'b0;
          cur_nxt.commState[PRH_ST_SET_BIT] = 1'b1;
        end
      end
      PRH_IDLE: begin
        cur_nxt.idx = 5'h0;
        // setting read has priority; the other bit waits
        if (cur_r.request[PRH_REQ_SET_BIT]) begin
          cur_nxt.state = PRH_SETREAD;
          cur_nxt.commState[PRH_ST_SET_BIT] = 1'b0;
        end else if (cur_r.request[PRH_REQ_MON_BIT]) begin
          cur_nxt.state = PRH_MONWRITE;
          cur_nxt.commState[PRH_ST_MON_BIT] = 1'b0;
        end
      end
      default: cur_nxt.state = PRH_GATHER;
    endcase
    cur_nxt.busy = (cur_nxt.state != PRH_IDLE);
    // ======================================================
    // faults; set wins over software clear
    if (backupFail) cur_nxt.errWord[PRH_ERR_BACKUP_BIT] = 1'b1;
    if (stackFail) cur_nxt.errWord[PRH_ERR_STACK_BIT] = 1'b1;
    if (netFail) cur_nxt.errWord[PRH_ERR_NET_BIT] = 1'b1;
    if (majorFail) cur_nxt.majorFault = 1'b1; // sticky until reset
    if (cur_r.flashCnt >= 32'(FLASH_CYC - 1)) begin
      cur_nxt.flashCnt = 32'h0;
      cur_nxt.flashPhase = !cur_r.flashPhase;
    end else begin
      cur_nxt.flashCnt = cur_r.flashCnt + 32'h1;
    end
    // major fault masks the green pattern
    cur_nxt.red = cur_nxt.majorFault && cur_r.flashPhase;
    cur_nxt.green = !cur_nxt.majorFault && (cur_nxt.errWord != 16'h0)
      && cur_r.flashPhase;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      cur_r <= '0;
      cur_r.state <= PRH_GATHER;
      cur_r.busy <= 1'b1;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign wbDatOut = cur_r.datOut;
  assign wbAck = cur_r.ack;
  assign busy = cur_r.busy;
  assign lampGreen = cur_r.green;
  assign lampRed = cur_r.red;
endmodule
`default_nettype wire

// ---- prh_pkg.sv ----
/*
  package for the controller register handshake engine: register map,
  state codes, error bit positions, timing constants.
  assumes a 40 MHz clock and a classic wishbone slave with 32-bit data.
*/
package prh_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] PRH_OFF_CTRL = 8'h00;
  localparam logic [7:0] PRH_OFF_REQUEST = 8'h04;
  localparam logic [7:0] PRH_OFF_STATE = 8'h08;
  localparam logic [7:0] PRH_OFF_SYSSTATE = 8'h0C;
  localparam logic [7:0] PRH_OFF_ERROR = 8'h10;
  localparam logic [7:0] PRH_OFF_FAULT = 8'h14;
  localparam logic [7:0] PRH_OFF_SETPOINT = 8'h20;
  // ==========================================================
  // field positions
  localparam int PRH_REQ_SET_BIT = 0;
  localparam int PRH_REQ_MON_BIT = 1;
  localparam int PRH_ST_SET_BIT = 1;
  localparam int PRH_ST_MON_BIT = 2;
  localparam int PRH_ERR_BACKUP_BIT = 1;
  localparam int PRH_ERR_STACK_BIT = 6;
  localparam int PRH_ERR_NET_BIT = 9;
  localparam logic [15:0] PRH_SYS_READY = 16'h0001;
  localparam logic [15:0] PRH_RST_WORD = 16'h0000;
  // ==========================================================
  // lamp and gather timing
  localparam int PRH_CLK_HZ = 40000000;
  localparam int PRH_FLASH_MS = 250;
  localparam int PRH_FLASH_CYC = PRH_CLK_HZ / 1000 * PRH_FLASH_MS;
  localparam int PRH_GATHER_CYC = 16;
  // ==========================================================
  typedef enum logic [2:0] {
    PRH_GATHER, PRH_MONINIT, PRH_IDLE, PRH_SETREAD, PRH_MONWRITE
  } prh_state_type;
  typedef enum logic [1:0] {PRH_LAMP_OFF, PRH_LAMP_GREEN, PRH_LAMP_RED} prh_lamp_type;
endpackage

// ---- prh_unit_model.sv ----
/* stand-in for the attached function modules.
   assumes one clock and srst; gatherDone rises 17 cycles after reset. */
`timescale 1ns/1ps
`default_nettype none
module prh_unit_model (
  input wire logic clk,
  input wire logic srst,
  output logic gatherDone
);
  logic [4:0] cnt;
  // =====
  // level stays up: the engine only samples it while gathering
  always_ff @(posedge clk) begin
    cnt <= srst ? 5'h00 : cnt + {4'h0, ~cnt[4]};
    gatherDone <= !srst && cnt[4];
  end
endmodule
`default_nettype wire

// ---- prh_handshake_assertions.sv ----
/* port checker for the handshake engine.
   assumes FLASH_CYC of 4 and one clock; bound from the bench. */
`timescale 1ns/1ps
`default_nettype none
module prh_handshake_assertions import prh_pkg::*; #(parameter int FLASH_CYC = 4) (
  input wire logic clk, srst, gatherDone, backupFail, stackFail, netFail, majorFail,
  input wire logic wbCyc, wbStb, wbWe, wbAck, busy, lampGreen, lampRed,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn, wbDatOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // =====
  // bus, transfer and lamp relations
  sequence s_req;
    wbAck && wbWe && wbAdr == PRH_OFF_REQUEST && wbDatIn[1:0] != 2'h0 && !busy;
  endsequence
  property p_ack; wbCyc && wbStb && !wbAck |=> wbAck; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_pulse; wbAck |=> !wbAck; endproperty
  a_pulse: assert property (p_pulse) else $error("ack held");
  property p_sys; wbAck && !wbWe && wbAdr == PRH_OFF_SYSSTATE && !busy |-> wbDatOut == 32'h1; endproperty
  a_sys: assert property (p_sys) else $error("system state");
  property p_start; s_req |-> ##[1:3] busy; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_len; $rose(busy) |=> busy [*8]; endproperty
  a_len: assert property (p_len) else $error("short transfer");
  property p_excl; !(lampGreen && lampRed); endproperty
  a_excl: assert property (p_excl) else $error("both lamps");
  property p_red; majorFail |-> ##[1:10] lampRed; endproperty
  a_red: assert property (p_red) else $error("no red");
  property p_grn; (backupFail || stackFail || netFail) && !majorFail |-> ##[1:10] lampGreen; endproperty
  a_grn: assert property (p_grn) else $error("no green");
endmodule
`default_nettype wire

// ---- prh_handshake_tb.sv ----
/* bench for the handshake engine: classic bus master, row table, hand tests.
   assumes the unit model and checker files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module prh_handshake_tb import prh_pkg::*;;
  typedef struct {logic we; logic [7:0] adr; logic [31:0] dat, exp;} prh_row_type;
  logic clk = 0, srst = 1, gatherDone, backupFail = 0, stackFail = 0, netFail = 0;
  logic majorFail = 0, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, busy, lampGreen, lampRed;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'hF;
  logic [31:0] wbDatIn = 32'h0, wbDatOut, q;
  logic [31:0] errs [3] = '{32'h2, 32'h42, 32'h242};
  int errCount = 0, samplesChecked = 0;
  prh_row_type rows [5] = '{'{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b1, 8'h20, 32'h64, 32'h0},
    '{1'b0, 8'h20, 32'h0, 32'h64}, '{1'b1, 8'h0C, 32'h5, 32'h0}, '{1'b0, 8'h0C, 32'h0, 32'h1}};
  always #12.5 clk = ~clk;
  prh_unit_model um (.clk(clk), .srst(srst), .gatherDone(gatherDone));
  prh_handshake #(.FLASH_CYC(4)) dut (
    .clk(clk),
    .srst(srst),
    .gatherDone(gatherDone),
    .backupFail(backupFail),
    .stackFail(stackFail),
    .netFail(netFail),
    .majorFail(majorFail),
    .wbCyc(wbCyc),
    .wbStb(wbStb),
    .wbWe(wbWe),
    .wbAdr(wbAdr),
    .wbSel(wbSel),
    .wbDatIn(wbDatIn),
    .wbDatOut(wbDatOut),
    .wbAck(wbAck),
    .busy(busy),
    .lampGreen(lampGreen),
    .lampRed(lampRed)
  );
  // =====
  // tasks
  task complete_run;
    if (errCount == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task check(input string n, input logic [31:0] e, g);
    samplesChecked++;
    if (g !== e) begin
      errCount++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task stop;
    errCount++;
    complete_run;
  endtask
  // request held until ack is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatIn} <= {2'h3, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    q = wbDatOut;
    {wbCyc, wbStb} <= 2'h0;
    if (wbAck !== 1'b1) stop;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, m);
    bus(1'b0, a, 32'h0);
    check("register", e, q & m);
  endtask
  task idle;
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (busy !== 1'b0) stop;
  endtask
  task see(input logic red);
    logic s;
    s = 1'b0;
    repeat (20) begin
      @(posedge clk);
      if ((red ? lampRed : lampGreen) === 1'b1) s = 1'b1;
    end
    check("lamp", 32'h1, {31'h0, s});
  endtask
  // =====
  // sequence
  initial begin
    repeat (6) @(posedge clk);
    check("busy", 32'h1, {31'h0, busy});
    srst <= 1'b0;
    rd(PRH_OFF_SYSSTATE, 32'h0, 32'hFFFF);
    idle;
    for (int i = 0; i < 5; i++) begin
      bus(rows[i].we, rows[i].adr, rows[i].dat);
      if (!rows[i].we) check("row", rows[i].exp, q);
    end
    bus(1'b1, PRH_OFF_REQUEST, 32'h1);
    rd(PRH_OFF_REQUEST, 32'h1, 32'h3);
    idle;
    rd(PRH_OFF_REQUEST, 32'h0, 32'h3);
    rd(PRH_OFF_STATE, 32'h2, 32'h2);
    bus(1'b1, PRH_OFF_SETPOINT, 32'h99);
    bus(1'b1, PRH_OFF_REQUEST, 32'h2);
    bus(1'b1, PRH_OFF_REQUEST, 32'h1);
    idle;
    idle;
    rd(PRH_OFF_SETPOINT, 32'h64, 32'hFFFF);
    rd(PRH_OFF_REQUEST, 32'h0, 32'h3);
    rd(PRH_OFF_STATE, 32'h6, 32'h6);
    rd(8'h18, 32'h0, 32'hFFFF);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      {netFail, stackFail, backupFail} <= 3'h1 << k;
      @(posedge clk);
      {netFail, stackFail, backupFail} <= 3'h0;
      rd(PRH_OFF_ERROR, errs[k], 32'hFFFF);
    end
    see(1'b0);
    bus(1'b1, PRH_OFF_ERROR, 32'h242);
    rd(PRH_OFF_ERROR, 32'h0, 32'hFFFF);
    @(posedge clk);
    majorFail <= 1'b1;
    @(posedge clk);
    majorFail <= 1'b0;
    rd(PRH_OFF_FAULT, 32'h1, 32'h1);
    see(1'b1);
    complete_run;
  end
endmodule
bind prh_handshake prh_handshake_assertions #(.FLASH_CYC(FLASH_CYC)) chk (
  .clk(clk),
  .srst(srst),
  .gatherDone(gatherDone),
  .backupFail(backupFail),
  .stackFail(stackFail),
  .netFail(netFail),
  .majorFail(majorFail),
  .wbCyc(wbCyc),
  .wbStb(wbStb),
  .wbWe(wbWe),
  .wbAck(wbAck),
  .busy(busy),
  .lampGreen(lampGreen),
  .lampRed(lampRed),
  .wbAdr(wbAdr),
  .wbSel(wbSel),
  .wbDatIn(wbDatIn),
  .wbDatOut(wbDatOut)
);
`default_nettype wire
